// >>> verilog/irq_pin_ctrl.sv
// Contract
// - Bus-style pin high selects strobe bus.
// - Strobe bus: channel D select active low.
// - Read/write bus ignores channel D select.
// - Read/write bus: B/C selects become address.
// - Strobe: channel A pin driven when enabled.
// - Strobe: B/C/D pins individually enabled or floating.
// - Read/write: channel A is open-drain device request.
// - Read/write: B/C/D pins held low.
// - Override high enables all outputs continuously.
// - Override low: enable bit alone decides.
// - Override active high, unconnected reads low.
// - Variant without override pin always enabled.
// - Per-channel active-low transmit ready output.
// - Per-channel active-low receive ready output.
// - Combined ready outputs OR all channels.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

module irq_pin_ctrl #(
   parameter bit HAS_OVERRIDE_PIN = 1'b1
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic BUS_STYLE_SEL,
   input wire logic CHAN_A_SELECT_N,
   input wire logic CHAN_B_SELECT_N,
   input wire logic CHAN_C_SELECT_N,
   input wire logic CHAN_D_SELECT_N,
   input wire logic IRQ_OUTPUT_OVERRIDE,
   input wire logic [irq_pin_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [irq_pin_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [irq_pin_pkg::DATA_W-1:0] REG_RDATA,
   input wire logic [irq_pin_pkg::NUM_CHAN-1:0] TX_SPACE_AVAIL,
   input wire logic [irq_pin_pkg::NUM_CHAN-1:0] RX_DATA_AVAIL,
   input wire logic [irq_pin_pkg::NUM_CHAN-1:0] LINE_EVENT,
   output logic CHAN_A_IRQ_OUT,
   output logic CHAN_A_IRQ_OE_N,
   output logic CHAN_B_IRQ_OUT,
   output logic CHAN_B_IRQ_OE_N,
   output logic CHAN_C_IRQ_OUT,
   output logic CHAN_C_IRQ_OE_N,
   output logic CHAN_D_IRQ_OUT,
   output logic CHAN_D_IRQ_OE_N,
   output logic DEVICE_IRQ,
   output logic CHAN_A_TX_SPACE_READY_N,
   output logic CHAN_B_TX_SPACE_READY_N,
   output logic CHAN_C_TX_SPACE_READY_N,
   output logic CHAN_D_TX_SPACE_READY_N,
   output logic CHAN_A_RX_DATA_READY_N,
   output logic CHAN_B_RX_DATA_READY_N,
   output logic CHAN_C_RX_DATA_READY_N,
   output logic CHAN_D_RX_DATA_READY_N,
   output logic COMBINED_TX_SPACE_READY_N,
   output logic COMBINED_RX_DATA_READY_N
);
   import irq_pin_pkg::*;

   wire strobe_style;
   wire [NUM_CHAN-1:0] strobe_sel;
   wire [NUM_CHAN-1:0] rw_sel;
   wire [NUM_CHAN-1:0] chan_sel;
   wire [1:0] rw_idx;
   wire [1:0] strobe_idx;
   wire [1:0] rd_idx;
   wire any_sel;
   wire wr_hit;
   wire rd_hit;
   wire override_eff;
   wire any_pend;
   wire [DATA_W-1:0] rd_word;
   wire addr_mcr;
   wire addr_stat;
   wire addr_mask;
   wire addr_pst;

   logic [DATA_W-1:0] mcr_q [NUM_CHAN];
   logic [EVT_W-1:0] stat_q [NUM_CHAN];
   logic [EVT_W-1:0] mask_q [NUM_CHAN];
   logic [NUM_CHAN-1:0] tx_prev_q;
   logic [NUM_CHAN-1:0] rx_prev_q;
   logic [NUM_CHAN-1:0] pend;
   logic [NUM_CHAN-1:0] pin_en;
   logic [NUM_CHAN-1:0] irq_out_d;
   logic [NUM_CHAN-1:0] irq_out_q;
   logic [NUM_CHAN-1:0] irq_oe_n_d;
   logic [NUM_CHAN-1:0] irq_oe_n_q;
   logic [NUM_CHAN-1:0] tx_rdy_n_q;
   logic [NUM_CHAN-1:0] rx_rdy_n_q;
   logic comb_tx_n_q;
   logic comb_rx_n_q;
   logic dev_irq_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] reg_word [NUM_CHAN];

   assign strobe_style = (BUS_STYLE_SEL == BUS_STROBE);

   // Strobe style: each channel has its own active-low select, D included.
   assign strobe_sel = {~CHAN_D_SELECT_N, ~CHAN_C_SELECT_N, ~CHAN_B_SELECT_N, ~CHAN_A_SELECT_N};

   // Read/write style: one select, the B and C lines are channel address bits, D is never looked at.
   assign rw_idx = {CHAN_C_SELECT_N, CHAN_B_SELECT_N};
   assign rw_sel = CHAN_A_SELECT_N ? 4'h0 : (4'h1 << rw_idx);

   assign chan_sel = strobe_style ? strobe_sel : rw_sel;
   assign any_sel = |chan_sel;

   // Several strobe selects at once write every selected channel; a read returns the lowest one.
   assign strobe_idx = strobe_sel[0] ? 2'h0 : strobe_sel[1] ? 2'h1 : strobe_sel[2] ? 2'h2 : 2'h3;
   assign rd_idx = strobe_style ? strobe_idx : rw_idx;

   assign wr_hit = REG_WR & any_sel;
   assign rd_hit = REG_RD & any_sel;

   // Offsets decode once; each channel only adds its own select.
   assign addr_mcr = (REG_ADDR == OFS_MODEM_CTRL);
   assign addr_stat = (REG_ADDR == OFS_IRQ_STATUS);
   assign addr_mask = (REG_ADDR == OFS_IRQ_MASK);
   assign addr_pst = (REG_ADDR == OFS_PIN_STATE);

   // The pin variant without the override input behaves as if it were tied high.
   // The override only has meaning on the strobe bus; the system keeps it low otherwise.
   assign override_eff = strobe_style & (HAS_OVERRIDE_PIN ? IRQ_OUTPUT_OVERRIDE : 1'b1);

   assign any_pend = |pend;

   genvar c;
   generate
      for (c = 0; c < NUM_CHAN; c++) begin : g_chan
         wire wr_c;
         wire [EVT_W-1:0] evt;
         wire [EVT_W-1:0] w1c;
         wire [EVT_W-1:0] stat_d;
         wire wr_mcr;
         wire wr_stat;
         wire wr_mask;
         wire [DATA_W-1:0] stat_word;
         wire [DATA_W-1:0] mask_word;
         wire [DATA_W-1:0] pst_word;

         assign wr_c = wr_hit & chan_sel[c];
         assign wr_mcr = wr_c & addr_mcr;
         assign wr_stat = wr_c & addr_stat;
         assign wr_mask = wr_c & addr_mask;

         // Events are rising edges of the FIFO levels plus the line event pulse.
         assign evt[EVT_TX] = TX_SPACE_AVAIL[c] & ~tx_prev_q[c];
         assign evt[EVT_RX] = RX_DATA_AVAIL[c] & ~rx_prev_q[c];
         assign evt[EVT_LINE] = LINE_EVENT[c];

         assign w1c = wr_stat ? REG_WDATA[EVT_W-1:0] : '0;

         // A new event in the cycle of its clear keeps the bit set.
         assign stat_d = (stat_q[c] & ~w1c) | evt;

         assign pend[c] = |(stat_q[c] & mask_q[c]);

         assign pin_en[c] = override_eff | mcr_q[c][IRQ_OE_BIT];

         if (c == 0) begin : g_pin_a
            // Strobe: driven with the channel request; read/write: open-drain low while anything pends.
            assign irq_out_d[c] = strobe_style ? pend[c] : PIN_LOW;
            assign irq_oe_n_d[c] = strobe_style ? ~pin_en[c] : ~any_pend;
         end else begin : g_pin_bcd
            assign irq_out_d[c] = strobe_style ? pend[c] : PIN_LOW;
            assign irq_oe_n_d[c] = strobe_style ? ~pin_en[c] : OE_DRIVE_N;
         end

         assign stat_word = DATA_W'(stat_q[c]);
         assign mask_word = DATA_W'(mask_q[c]);

         // Bits above the strobe-style flag read as zero.
         assign pst_word[DATA_W-1:PST_STROBE+1] = '0;
         assign pst_word[PST_STROBE] = strobe_style;
         assign pst_word[PST_EN] = pin_en[c];
         assign pst_word[PST_PEND] = pend[c];
         assign pst_word[PST_RX] = RX_DATA_AVAIL[c];
         assign pst_word[PST_TX] = TX_SPACE_AVAIL[c];

         assign reg_word[c] = addr_mcr ? mcr_q[c] :
                              addr_stat ? stat_word :
                              addr_mask ? mask_word :
                              addr_pst ? pst_word :
                              RDATA_IDLE;

         always_ff @(posedge REF_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               mcr_q[c] <= MCR_RESET;
            end else if (wr_mcr) begin
               mcr_q[c] <= REG_WDATA;
            end
         end

         always_ff @(posedge REF_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               mask_q[c] <= MASK_RESET;
            end else if (wr_mask) begin
               mask_q[c] <= REG_WDATA[EVT_W-1:0];
            end
         end

         always_ff @(posedge REF_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               stat_q[c] <= STATUS_RESET;
            end else begin
               stat_q[c] <= stat_d;
            end
         end
      end
   endgenerate

   assign rd_word = reg_word[rd_idx];

   // Edge memories start high, so a level already up when reset lifts is not taken as an event.
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tx_prev_q <= '1;
         rx_prev_q <= '1;
      end else begin
         tx_prev_q <= TX_SPACE_AVAIL;
         rx_prev_q <= RX_DATA_AVAIL;
      end
   end

   // Read data stand for exactly one cycle after the strobe, zero otherwise.
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_q <= RDATA_IDLE;
      end else begin
         rdata_q <= rd_hit ? rd_word : RDATA_IDLE;
      end
   end

   // Interrupt pins float from reset until the first edge after release.
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_out_q <= {NUM_CHAN{PIN_LOW}};
      end else begin
         irq_out_q <= irq_out_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_oe_n_q <= {NUM_CHAN{OE_FLOAT_N}};
      end else begin
         irq_oe_n_q <= irq_oe_n_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dev_irq_q <= PIN_LOW;
      end else begin
         dev_irq_q <= any_pend;
      end
   end

   // Ready outputs are the inverted levels; the combined ones go low when any channel is ready.
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tx_rdy_n_q <= {NUM_CHAN{READY_IDLE_N}};
         rx_rdy_n_q <= {NUM_CHAN{READY_IDLE_N}};
      end else begin
         tx_rdy_n_q <= ~TX_SPACE_AVAIL;
         rx_rdy_n_q <= ~RX_DATA_AVAIL;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         comb_tx_n_q <= READY_IDLE_N;
         comb_rx_n_q <= READY_IDLE_N;
      end else begin
         comb_tx_n_q <= ~(|TX_SPACE_AVAIL);
         comb_rx_n_q <= ~(|RX_DATA_AVAIL);
      end
   end

   assign REG_RDATA = rdata_q;
   assign DEVICE_IRQ = dev_irq_q;
   assign CHAN_A_IRQ_OUT = irq_out_q[0];
   assign CHAN_A_IRQ_OE_N = irq_oe_n_q[0];
   assign CHAN_B_IRQ_OUT = irq_out_q[1];
   assign CHAN_B_IRQ_OE_N = irq_oe_n_q[1];
   assign CHAN_C_IRQ_OUT = irq_out_q[2];
   assign CHAN_C_IRQ_OE_N = irq_oe_n_q[2];
   assign CHAN_D_IRQ_OUT = irq_out_q[3];
   assign CHAN_D_IRQ_OE_N = irq_oe_n_q[3];
   assign CHAN_A_TX_SPACE_READY_N = tx_rdy_n_q[0];
   assign CHAN_B_TX_SPACE_READY_N = tx_rdy_n_q[1];
   assign CHAN_C_TX_SPACE_READY_N = tx_rdy_n_q[2];
   assign CHAN_D_TX_SPACE_READY_N = tx_rdy_n_q[3];
   assign CHAN_A_RX_DATA_READY_N = rx_rdy_n_q[0];
   assign CHAN_B_RX_DATA_READY_N = rx_rdy_n_q[1];
   assign CHAN_C_RX_DATA_READY_N = rx_rdy_n_q[2];
   assign CHAN_D_RX_DATA_READY_N = rx_rdy_n_q[3];
   assign COMBINED_TX_SPACE_READY_N = comb_tx_n_q;
   assign COMBINED_RX_DATA_READY_N = comb_rx_n_q;

endmodule : irq_pin_ctrl

// >>> pkg/irq_pin_pkg.sv
package irq_pin_pkg;

   localparam int NUM_CHAN = 4;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int EVT_W = 3;

   // Per-channel register offsets, chosen within the three local address lines.
   localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 3'h3;

   // Field positions.
   localparam int IRQ_OE_BIT = 3;
   localparam int EVT_TX = 0;
   localparam int EVT_RX = 1;
   localparam int EVT_LINE = 2;
   localparam int PST_TX = 0;
   localparam int PST_RX = 1;
   localparam int PST_PEND = 2;
   localparam int PST_EN = 3;
   localparam int PST_STROBE = 4;

   // Reset values.
   localparam logic [DATA_W-1:0] MCR_RESET = 8'h00;
   localparam logic [EVT_W-1:0] STATUS_RESET = 3'h0;
   localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
   localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

   // Level of the bus-style pin that picks the separate strobe bus.
   localparam logic BUS_STROBE = 1'b1;

   // Pin drive levels.
   localparam logic PIN_LOW = 1'b0;
   localparam logic OE_DRIVE_N = 1'b0;
   localparam logic OE_FLOAT_N = 1'b1;
   localparam logic READY_IDLE_N = 1'b1;

endpackage : irq_pin_pkg

// >>> sim/irq_wire_model.sv
`timescale 1ns/1ps

// Board side of the four interrupt wires as the host sees them.
module irq_wire_model (
   input wire logic [3:0] OUT,
   input wire logic [3:0] OE_N,
   output logic [3:0] LVL
);
   // Only the shared request line carries a pull-up resistor.
   assign LVL[0] = OE_N[0] ? 1'b1 : OUT[0];
   // Unpulled floating wires show the inverse so a stale value never passes.
   assign LVL[3:1] = (OE_N[3:1] & ~OUT[3:1]) | (~OE_N[3:1] & OUT[3:1]);
endmodule : irq_wire_model

// >>> sim/irq_pin_ctrl_assertions.sv
`timescale 1ns/1ps

module irq_pin_ctrl_checker (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic BUS_STYLE_SEL,
   input wire logic IRQ_OUTPUT_OVERRIDE,
   input wire logic [3:0] TX_SPACE_AVAIL,
   input wire logic [3:0] RX_DATA_AVAIL,
   input wire logic CHAN_A_IRQ_OUT,
   input wire logic CHAN_A_IRQ_OE_N,
   input wire logic CHAN_B_IRQ_OUT,
   input wire logic CHAN_B_IRQ_OE_N,
   input wire logic CHAN_D_IRQ_OE_N,
   input wire logic DEVICE_IRQ,
   input wire logic CHAN_A_TX_SPACE_READY_N,
   input wire logic CHAN_D_RX_DATA_READY_N,
   input wire logic COMBINED_TX_SPACE_READY_N,
   input wire logic COMBINED_RX_DATA_READY_N
);
   logic up_q;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   // Past values seen at the first edge after release still belong to reset.
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) up_q <= 1'b0;
      else up_q <= 1'b1;
   end

   property p_tx_ready; up_q |-> CHAN_A_TX_SPACE_READY_N == !$past(TX_SPACE_AVAIL[0]); endproperty
   a_tx_ready: assert property (p_tx_ready) else $error("transmit ready pin wrong");
   property p_rx_ready; up_q |-> CHAN_D_RX_DATA_READY_N == !$past(RX_DATA_AVAIL[3]); endproperty
   a_rx_ready: assert property (p_rx_ready) else $error("receive ready pin wrong");
   property p_comb_tx; up_q |-> COMBINED_TX_SPACE_READY_N == !(|$past(TX_SPACE_AVAIL)); endproperty
   a_comb_tx: assert property (p_comb_tx) else $error("combined transmit ready wrong");
   property p_comb_rx; up_q |-> COMBINED_RX_DATA_READY_N == !(|$past(RX_DATA_AVAIL)); endproperty
   a_comb_rx: assert property (p_comb_rx) else $error("combined receive ready wrong");
   property p_rw_low; up_q && !$past(BUS_STYLE_SEL) |-> !CHAN_B_IRQ_OUT && !CHAN_B_IRQ_OE_N && !CHAN_D_IRQ_OE_N;
   endproperty
   a_rw_low: assert property (p_rw_low) else $error("unused interrupt pins not low");
   property p_rw_req; up_q && !$past(BUS_STYLE_SEL) |-> !CHAN_A_IRQ_OUT && CHAN_A_IRQ_OE_N == !DEVICE_IRQ;
   endproperty
   a_rw_req: assert property (p_rw_req) else $error("shared request not open drain");
   property p_override; up_q && $past(BUS_STYLE_SEL && IRQ_OUTPUT_OVERRIDE) |-> !CHAN_A_IRQ_OE_N
      && !CHAN_B_IRQ_OE_N && !CHAN_D_IRQ_OE_N; endproperty
   a_override: assert property (p_override) else $error("override did not enable pins");
   property p_pend; up_q && $past(BUS_STYLE_SEL) && CHAN_B_IRQ_OUT |-> DEVICE_IRQ; endproperty
   a_pend: assert property (p_pend) else $error("pin active with nothing pending");
endmodule : irq_pin_ctrl_checker

bind irq_pin_ctrl irq_pin_ctrl_checker irq_pin_ctrl_checker_i (.REF_CLK, .SYS_RST, .BUS_STYLE_SEL,
   .IRQ_OUTPUT_OVERRIDE, .TX_SPACE_AVAIL, .RX_DATA_AVAIL, .CHAN_A_IRQ_OUT, .CHAN_A_IRQ_OE_N, .CHAN_B_IRQ_OUT,
   .CHAN_B_IRQ_OE_N, .CHAN_D_IRQ_OE_N, .DEVICE_IRQ, .CHAN_A_TX_SPACE_READY_N, .CHAN_D_RX_DATA_READY_N,
   .COMBINED_TX_SPACE_READY_N, .COMBINED_RX_DATA_READY_N);

// >>> sim/tb.sv
`timescale 1ns/1ps

module tb;
   import irq_pin_pkg::*;
   logic clk = 0, rst = 1, style = 1, ovr = 0, wr_s = 0, rd_s = 0;
   logic [3:0] sel = 4'hF, tx = 0, rx = 0, ev = 0, out, oe, lvl, txn, rxn;
   logic [2:0] addr = 0;
   logic [7:0] wd = 0, rdata;
   logic dev, ctx, crx;
   int fail_count = 0, n_compared = 0, cyc = 0;

   always #25 clk = ~clk;
   irq_pin_ctrl irq_pin_ctrl_i (.REF_CLK(clk), .SYS_RST(rst), .BUS_STYLE_SEL(style), .CHAN_A_SELECT_N(sel[0]),
      .CHAN_B_SELECT_N(sel[1]), .CHAN_C_SELECT_N(sel[2]), .CHAN_D_SELECT_N(sel[3]), .IRQ_OUTPUT_OVERRIDE(ovr),
      .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .TX_SPACE_AVAIL(tx),
      .RX_DATA_AVAIL(rx), .LINE_EVENT(ev), .CHAN_A_IRQ_OUT(out[0]), .CHAN_A_IRQ_OE_N(oe[0]),
      .CHAN_B_IRQ_OUT(out[1]), .CHAN_B_IRQ_OE_N(oe[1]), .CHAN_C_IRQ_OUT(out[2]), .CHAN_C_IRQ_OE_N(oe[2]),
      .CHAN_D_IRQ_OUT(out[3]), .CHAN_D_IRQ_OE_N(oe[3]), .DEVICE_IRQ(dev),
      .CHAN_A_TX_SPACE_READY_N(txn[0]), .CHAN_B_TX_SPACE_READY_N(txn[1]), .CHAN_C_TX_SPACE_READY_N(txn[2]),
      .CHAN_D_TX_SPACE_READY_N(txn[3]), .CHAN_A_RX_DATA_READY_N(rxn[0]), .CHAN_B_RX_DATA_READY_N(rxn[1]),
      .CHAN_C_RX_DATA_READY_N(rxn[2]), .CHAN_D_RX_DATA_READY_N(rxn[3]),
      .COMBINED_TX_SPACE_READY_N(ctx), .COMBINED_RX_DATA_READY_N(crx));
   irq_wire_model irq_wire_model_i (.OUT(out), .OE_N(oe), .LVL(lvl));

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic [3:0] s, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      sel <= s; addr <= a; wd <= d; wr_s <= 1'b1;
      @(posedge clk);
      sel <= 4'hF; wr_s <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] s, input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      sel <= s; addr <= a; rd_s <= 1'b1;
      @(posedge clk);
      sel <= 4'hF; rd_s <= 1'b0;
      #1 chk("read data", e, rdata);
   endtask : rd

   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 4'h0;
      tick();
      tick();
   endtask : pulse

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         print_verdict();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      tick();
      chk("pin enables", 8'h0F, {4'h0, oe});
      rd(4'hE, OFS_MODEM_CTRL, MCR_RESET);
      rd(4'hE, 3'h5, RDATA_IDLE);
      wr(4'hE, OFS_MODEM_CTRL, 8'h08);
      wr(4'h7, OFS_MODEM_CTRL, 8'h08);
      tick();
      chk("pin enables", 8'h06, {4'h0, oe});
      wr(4'hD, OFS_MODEM_CTRL, 8'h08);
      wr(4'hD, OFS_IRQ_MASK, 8'h04);
      pulse(4'h2);
      chk("chan b request", 8'h03, {6'h0, dev, out[1]});
      rd(4'hD, OFS_IRQ_STATUS, 8'h04);
      wr(4'hD, OFS_IRQ_STATUS, 8'h04);
      tick();
      chk("chan b request", 8'h00, {6'h0, dev, out[1]});
      wr(4'hD, OFS_IRQ_MASK, 8'h00);
      pulse(4'h2);
      chk("masked request", 8'h00, {6'h0, dev, out[1]});
      ovr <= 1'b1;
      tick();
      tick();
      chk("override enables", 8'h00, {4'h0, oe});
      ovr <= 1'b0;
      tick();
      tick();
      chk("bit enables", 8'h04, {4'h0, oe});
      tx <= 4'h4;
      rx <= 4'h8;
      tick();
      tick();
      chk("ready pins", 8'hB7, {txn, rxn});
      chk("combined ready", 8'h00, {6'h0, ctx, crx});
      style <= 1'b0;
      tick();
      tick();
      chk("rw pins", 8'h01, {out, oe});
      wr(4'hE, OFS_IRQ_MASK, 8'h04);
      pulse(4'h8);
      chk("shared wire", 8'h02, {6'h0, dev, lvl[0]});
      rd(4'hE, OFS_IRQ_STATUS, 8'h06);
      rd(4'hA, OFS_MODEM_CTRL, 8'h08);
      rd(4'hC, OFS_MODEM_CTRL, 8'h00);
      rd(4'h7, OFS_IRQ_MASK, RDATA_IDLE);
      wr(4'hE, OFS_IRQ_STATUS, 8'h04);
      tick();
      chk("shared wire", 8'h01, {6'h0, dev, lvl[0]});
      print_verdict();
   end
endmodule : tb
